/* File: dqs_cfg.svh */
// Offsets, field positions, reset values and limits of the descriptor queue scheduler
`ifndef DQS_CFG_SVH
`define DQS_CFG_SVH
`define DQS_NUM_Q 3
`define DQS_GLOBAL_PAGE 4'h1
`define DQS_QR_LB 3'h0
`define DQS_QR_UB 3'h1
`define DQS_QR_HEAD 3'h2
`define DQS_QR_TAIL 3'h3
`define DQS_QR_LEN 3'h4
`define DQS_QR_THR 3'h5
`define DQS_QR_ENQ 3'h6
`define DQS_GR_CTRL 5'h00
`define DQS_GR_STAT 5'h01
`define DQS_GR_REQSZ 5'h02
`define DQS_GR_LDLO 5'h03
`define DQS_GR_LDHI 5'h04
`define DQS_CB_DIAG 0
`define DQS_CB_EN 1
`define DQS_CB_FAIR 2
`define DQS_CB_REARB 3
`define DQS_CTRL_RST 5'h01
`define DQS_LB_ZERO_BITS 9
`define DQS_LD_ZERO_BITS 12
`define DQS_ENTRY_BYTES 64'h0000_0000_0000_0008
`define DQS_LEN_STEP 32'h0000_0008
`define DQS_SIZE_UNIT 32'h0000_0200
`define DQS_REQ_MAX 16'hffff
`define DQS_CNT_W 6
`endif

/* File: dqs_pkg.sv */
// Types shared by the descriptor queue scheduler files
package dqs_pkg;
   typedef enum logic [1:0] {DQS_ARB_REQ, DQS_ARB_CHAIN, DQS_ARB_DESC} dqs_rearb_t;
   typedef enum logic [1:0] {DQS_S_IDLE, DQS_S_ISSUE, DQS_S_WAIT} dqs_state_t;
   typedef struct packed {
      logic [1:0] queue;
      logic [63:0] slot;
      logic [15:0] max_len;
      logic word4_en;
   } dqs_disp_t;
   typedef struct packed {
      logic req_done;
      logic desc_done;
      logic chain_done;
      logic error;
   } dqs_evt_t;
   typedef struct packed {
      logic valid;
      logic [1:0] queue;
      logic [63:0] slot;
      logic [63:0] chain;
      logic [5:0] count;
   } dqs_enq_t;
endpackage

/* File: dqs_queue.sv */
// One circular descriptor queue: bounds, head, tail and length
`timescale 1ns/100ps
`include "dqs_cfg.svh"
module dqs_queue (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic wr_lb,
   input wire logic wr_ub,
   input wire logic wr_head,
   input wire logic [63:0] wdata,
   input wire logic enq,
   input wire logic deq,
   output logic [63:0] lb,
   output logic [2:0] ub_enc,
   output logic [63:0] head,
   output logic [63:0] tail,
   output logic [31:0] len,
   output logic full
);
   logic [63:0] lb_ff, head_ff, tail_ff;
   logic [2:0] enc_ff;
   logic [31:0] len_ff, size;
   logic [63:0] bound, head_nxt, tail_nxt, lb_new;
   assign size = `DQS_SIZE_UNIT << enc_ff;
   assign bound = lb_ff + {32'h0, size};
   assign head_nxt = (head_ff + `DQS_ENTRY_BYTES == bound) ? lb_ff : head_ff + `DQS_ENTRY_BYTES;
   assign tail_nxt = (tail_ff + `DQS_ENTRY_BYTES == bound) ? lb_ff : tail_ff + `DQS_ENTRY_BYTES;
   assign lb_new = {wdata[63:`DQS_LB_ZERO_BITS], {`DQS_LB_ZERO_BITS{1'b0}}};
   assign full = (len_ff == size);
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         lb_ff <= 64'h0;
         enc_ff <= 3'h0;
         head_ff <= 64'h0;
         tail_ff <= 64'h0;
         len_ff <= 32'h0;
      end else if (wr_lb) begin
         lb_ff <= lb_new;
         head_ff <= lb_new;
         tail_ff <= lb_new;
         len_ff <= 32'h0;
      end else begin
         if (wr_ub) begin
            enc_ff <= wdata[2:0];
         end
         if (wr_head) begin
            head_ff <= wdata;
         end else if (deq) begin
            head_ff <= head_nxt;
         end
         if (enq) begin
            tail_ff <= tail_nxt;
         end
         if (enq && !deq) begin
            len_ff <= len_ff + `DQS_LEN_STEP;
         end else if (deq && !enq) begin
            len_ff <= len_ff - `DQS_LEN_STEP;
         end
      end
   end
   assign lb = lb_ff;
   assign ub_enc = enc_ff;
   assign head = head_ff;
   assign tail = tail_ff;
   assign len = len_ff;
endmodule // dqs_queue

/* File: dqs_arb.sv */
// Queue arbiter: strict-plus-round-robin or fair rotation
`timescale 1ns/100ps
module dqs_arb (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [2:0] ready,
   input wire logic fair,
   input wire logic advance,
   input wire logic [1:0] gq,
   output logic [1:0] pick,
   output logic any
);
   logic [1:0] last_ff;
   logic [1:0] f1, f2, fair_pick, strict_pick;
   assign f1 = (last_ff == 2'd2) ? 2'd0 : last_ff + 2'd1;
   assign f2 = (f1 == 2'd2) ? 2'd0 : f1 + 2'd1;
   assign fair_pick = ready[f1] ? f1 : (ready[f2] ? f2 : last_ff);
   assign strict_pick = ready[0] ? 2'd0 :
                        (ready[1] && ready[2]) ? ((last_ff == 2'd1) ? 2'd2 : 2'd1) :
                        (ready[1] ? 2'd1 : 2'd2);
   assign pick = fair ? fair_pick : strict_pick;
   assign any = |ready;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         last_ff <= 2'd2;
      end else if (advance && (fair || gq != 2'd0)) begin
         last_ff <= gq;
      end
   end
endmodule // dqs_arb

/* File: dqs_sched.sv */
// Descriptor queue scheduler top: Avalon-MM registers, queues, dispatch to the mover
`timescale 1ns/100ps
`include "dqs_cfg.svh"
module dqs_sched (
   input wire logic CLK,
   input wire logic ARST_N,
   input wire logic [11:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [63:0] AVS_WRITEDATA,
   input wire logic [7:0] AVS_BYTEENABLE,
   output logic [63:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   input wire logic ADDR64,
   output logic DISP_VALID,
   input wire logic DISP_READY,
   output dqs_pkg::dqs_disp_t DISP,
   input wire dqs_pkg::dqs_evt_t MOVER_EVT,
   output dqs_pkg::dqs_enq_t ENQ,
   output logic [2:0] THRESH
);
   logic ack_ff;
   logic [63:0] rdata_ff;
   logic [4:0] ctrl_ff;
   logic [15:0] reqsz_ff;
   logic [63:0] ldlo_ff;
   logic [31:0] ldhi_ff;
   logic halt_ff;
   dqs_pkg::dqs_state_t state_ff, nxt_state;
   logic [1:0] gq_ff;
   dqs_pkg::dqs_disp_t disp_ff;
   dqs_pkg::dqs_enq_t enq_ff, nxt_enq;
   logic [31:0] thr_ff [0:2];

   logic [63:0] q_lb [0:2];
   logic [2:0] q_enc [0:2];
   logic [63:0] q_head [0:2];
   logic [63:0] q_tail [0:2];
   logic [31:0] q_len [0:2];
   logic [2:0] q_full, q_ready, q_wr_lb, q_wr_ub, q_wr_head, q_enq, q_deq, q_sel;

   function automatic logic [63:0] merge64(input logic [63:0] old, input logic [63:0] wd,
                                           input logic [7:0] be, input logic a64);
      logic [63:0] r;
      r = old;
      if (|be[3:0]) begin
         r[31:0] = wd[31:0];
      end
      if (|be[7:4]) begin
         r[63:32] = wd[63:32];
      end
      if (!a64) begin
         r[63:32] = 32'h0;
      end
      return r;
   endfunction

   // Bus decode
   wire req = AVS_READ | AVS_WRITE;
   wire wr_take = AVS_WRITE & ack_ff;
   wire [3:0] page = AVS_ADDRESS[11:8];
   wire [1:0] qidx = AVS_ADDRESS[7:6];
   wire [2:0] qreg = AVS_ADDRESS[5:3];
   wire [4:0] greg = AVS_ADDRESS[7:3];
   wire is_q = (page == 4'h0) && (qidx != 2'd3);
   wire is_g = (page == `DQS_GLOBAL_PAGE);
   wire diag = ctrl_ff[`DQS_CB_DIAG];
   // Diagnostic mode blocks new grants from idle so bounds can change safely; a waiting dispatch can still reissue
   wire run = ctrl_ff[`DQS_CB_EN] & ~diag & ~halt_ff;
   wire fair = ctrl_ff[`DQS_CB_FAIR];
   wire [1:0] rearb = ctrl_ff[`DQS_CB_REARB+1:`DQS_CB_REARB];
   wire g_ctrl = wr_take && is_g && (greg == `DQS_GR_CTRL);
   wire g_reqsz = wr_take && is_g && (greg == `DQS_GR_REQSZ);
   wire g_ldlo = wr_take && is_g && (greg == `DQS_GR_LDLO) && diag;
   wire g_ldhi = wr_take && is_g && (greg == `DQS_GR_LDHI) && diag;
   wire [63:0] sel_lb = (qidx < 2'd3) ? q_lb[qidx] : 64'h0;
   wire [63:0] sel_head = (qidx < 2'd3) ? q_head[qidx] : 64'h0;
   wire [63:0] wd_lb = merge64(sel_lb, AVS_WRITEDATA, AVS_BYTEENABLE, ADDR64);
   wire [63:0] wd_head = merge64(sel_head, AVS_WRITEDATA, AVS_BYTEENABLE, ADDR64);
   wire [63:0] wd_q = (qreg == `DQS_QR_HEAD) ? wd_head : wd_lb;
   wire [63:0] wd_enq = merge64(64'h0, AVS_WRITEDATA, AVS_BYTEENABLE, ADDR64);

   // Answer one cycle after the request is seen
   assign AVS_WAITREQUEST = req & ~ack_ff;
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= req & ~ack_ff;
      end
   end

   // Per-queue strobes and state
   genvar gi;
   generate
      for (gi = 0; gi < `DQS_NUM_Q; gi = gi + 1) begin : g_q
         assign q_sel[gi] = wr_take && is_q && (qidx == gi);
         assign q_wr_lb[gi] = q_sel[gi] && (qreg == `DQS_QR_LB);
         assign q_wr_ub[gi] = q_sel[gi] && (qreg == `DQS_QR_UB) && diag;
         assign q_wr_head[gi] = q_sel[gi] && (qreg == `DQS_QR_HEAD);
         // Full queue refuses the enqueue silently
         assign q_enq[gi] = q_sel[gi] && (qreg == `DQS_QR_ENQ) && !q_full[gi];
         // Only a clean chain end pops the head; an error leaves it for retry
         assign q_deq[gi] = (state_ff == dqs_pkg::DQS_S_WAIT) && MOVER_EVT.chain_done &&
                            !MOVER_EVT.error && (gq_ff == gi);
         // descriptor ready means queue holds work
         assign q_ready[gi] = (q_len[gi] != 32'h0);
         assign THRESH[gi] = (thr_ff[gi] != 32'h0) && (q_len[gi] >= thr_ff[gi]);
         dqs_queue u_queue (
            .clk(CLK),
            .arst_n(ARST_N),
            .wr_lb(q_wr_lb[gi]),
            .wr_ub(q_wr_ub[gi]),
            .wr_head(q_wr_head[gi]),
            .wdata(wd_q),
            .enq(q_enq[gi]),
            .deq(q_deq[gi]),
            .lb(q_lb[gi]),
            .ub_enc(q_enc[gi]),
            .head(q_head[gi]),
            .tail(q_tail[gi]),
            .len(q_len[gi]),
            .full(q_full[gi])
         );
         always_ff @(posedge CLK or negedge ARST_N) begin
            if (!ARST_N) begin
               thr_ff[gi] <= 32'h0;
            end else if (q_sel[gi] && (qreg == `DQS_QR_THR) && (|AVS_BYTEENABLE[3:0])) begin
               thr_ff[gi] <= AVS_WRITEDATA[31:0];
            end
         end
      end
   endgenerate

   // Global registers
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         ctrl_ff <= `DQS_CTRL_RST;
         reqsz_ff <= 16'h0;
      end else begin
         if (g_ctrl && (|AVS_BYTEENABLE[3:0])) begin
            ctrl_ff <= AVS_WRITEDATA[4:0];
         end
         if (g_reqsz && (|AVS_BYTEENABLE[3:0])) begin
            reqsz_ff <= AVS_WRITEDATA[15:0];
         end
      end
   end

   // Local descriptor range, diagnostic mode only
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         ldlo_ff <= 64'h0;
         ldhi_ff <= 32'h0;
      end else begin
         // upper half held zero in 32-bit mode
         if (g_ldlo) begin
            ldlo_ff <= merge64(ldlo_ff, AVS_WRITEDATA, AVS_BYTEENABLE, ADDR64) &
                       ~64'h0000_0000_0000_0fff;
         end
         if (g_ldhi && (|AVS_BYTEENABLE[3:0])) begin
            ldhi_ff <= {AVS_WRITEDATA[31:`DQS_LD_ZERO_BITS], {`DQS_LD_ZERO_BITS{1'b0}}};
         end
      end
   end

   // Read mux, captured while waitrequest is high
   logic [63:0] q_rd, g_rd, nxt_rdata;
   wire [1:0] rq = (qidx < 2'd3) ? qidx : 2'd0;
   always_comb begin
      if (qreg == `DQS_QR_LB) begin
         q_rd = q_lb[rq];
      end else if (qreg == `DQS_QR_UB) begin
         q_rd = {61'h0, q_enc[rq]};
      end else if (qreg == `DQS_QR_HEAD) begin
         q_rd = q_head[rq];
      end else if (qreg == `DQS_QR_TAIL) begin
         q_rd = q_tail[rq];
      end else if (qreg == `DQS_QR_LEN) begin
         q_rd = {32'h0, q_len[rq]};
      end else if (qreg == `DQS_QR_THR) begin
         q_rd = {32'h0, thr_ff[rq]};
      end else begin
         q_rd = 64'h0;
      end
   end
   always_comb begin
      if (greg == `DQS_GR_CTRL) begin
         g_rd = {59'h0, ctrl_ff};
      end else if (greg == `DQS_GR_STAT) begin
         g_rd = {56'h0, halt_ff, (state_ff != dqs_pkg::DQS_S_IDLE), gq_ff, 1'b0,
                 THRESH};
      end else if (greg == `DQS_GR_REQSZ) begin
         g_rd = {48'h0, reqsz_ff};
      end else if (greg == `DQS_GR_LDLO) begin
         g_rd = ldlo_ff;
      end else if (greg == `DQS_GR_LDHI) begin
         g_rd = {32'h0, ldhi_ff};
      end else begin
         g_rd = 64'h0;
      end
   end
   // Unmapped reads return zero
   always_comb begin
      if (is_q) begin
         nxt_rdata = q_rd;
      end else if (is_g) begin
         nxt_rdata = g_rd;
      end else begin
         nxt_rdata = 64'h0;
      end
   end
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         rdata_ff <= 64'h0;
      end else if (AVS_READ && !ack_ff) begin
         rdata_ff <= nxt_rdata;
      end
   end
   assign AVS_READDATA = rdata_ff;

   // Enqueue notice to the memory writer
   always_comb begin
      nxt_enq = '0;
      if (|q_enq) begin
         nxt_enq.valid = 1'b1;
         nxt_enq.queue = qidx;
         nxt_enq.slot = q_tail[rq];
         nxt_enq.count = wd_enq[`DQS_CNT_W-1:0];
         nxt_enq.chain = {wd_enq[63:`DQS_CNT_W], {`DQS_CNT_W{1'b0}}};
      end
   end
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         enq_ff <= '0;
      end else begin
         enq_ff <= nxt_enq;
      end
   end
   assign ENQ = enq_ff;

   logic [1:0] pick;
   logic pick_any;
   logic advance;
   dqs_arb u_arb (
      .clk(CLK),
      .arst_n(ARST_N),
      .ready(q_ready),
      .fair(fair),
      .advance(advance),
      .gq(gq_ff),
      .pick(pick),
      .any(pick_any)
   );

   // Scheduler sequencing
   wire evt_ok = MOVER_EVT.req_done | MOVER_EVT.desc_done | MOVER_EVT.chain_done;
   wire in_wait = (state_ff == dqs_pkg::DQS_S_WAIT);
   wire rel_req = MOVER_EVT.req_done && (rearb == dqs_pkg::DQS_ARB_REQ);
   wire rel_desc = MOVER_EVT.desc_done && (rearb != dqs_pkg::DQS_ARB_CHAIN);
   always_comb begin
      nxt_state = state_ff;
      advance = 1'b0;
      case (state_ff)
         dqs_pkg::DQS_S_IDLE: begin
            if (run && pick_any) begin
               nxt_state = dqs_pkg::DQS_S_ISSUE;
            end
         end
         dqs_pkg::DQS_S_ISSUE: begin
            if (DISP_READY) begin
               nxt_state = dqs_pkg::DQS_S_WAIT;
            end
         end
         dqs_pkg::DQS_S_WAIT: begin
            if (MOVER_EVT.error) begin
               nxt_state = dqs_pkg::DQS_S_WAIT;
            end else if (MOVER_EVT.chain_done || rel_req || rel_desc) begin
               advance = 1'b1;
               nxt_state = dqs_pkg::DQS_S_IDLE;
            end else if (evt_ok) begin
               nxt_state = halt_ff ? dqs_pkg::DQS_S_WAIT : dqs_pkg::DQS_S_ISSUE;
            end
         end
         default: begin
            nxt_state = dqs_pkg::DQS_S_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         state_ff <= dqs_pkg::DQS_S_IDLE;
         gq_ff <= 2'd0;
      end else begin
         state_ff <= nxt_state;
         // Granted queue frozen until the next grant
         if (state_ff == dqs_pkg::DQS_S_IDLE && nxt_state == dqs_pkg::DQS_S_ISSUE) begin
            gq_ff <= pick;
         end
      end
   end

   // recovered completion clears the halt; an error in the same cycle wins
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         halt_ff <= 1'b0;
      end else if (in_wait && MOVER_EVT.error) begin
         halt_ff <= 1'b1;
      end else if (in_wait && evt_ok) begin
         halt_ff <= 1'b0;
      end
   end

   // Dispatch word, latched as the grant is made
   // Head sampled once; a later head write leaves an issued request alone
   wire [15:0] max_len = (reqsz_ff == 16'h0) ? `DQS_REQ_MAX : reqsz_ff;
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         disp_ff <= '0;
      end else if (state_ff == dqs_pkg::DQS_S_IDLE && nxt_state == dqs_pkg::DQS_S_ISSUE) begin
         disp_ff.queue <= pick;
         disp_ff.slot <= q_head[pick];
         disp_ff.max_len <= max_len;
         // word four only with 64-bit addresses
         disp_ff.word4_en <= ADDR64;
      end
   end
   assign DISP = disp_ff;
   assign DISP_VALID = (state_ff == dqs_pkg::DQS_S_ISSUE);
endmodule // dqs_sched

/* File: dqs_sched_sva.sv */
// Port-level assertions for the descriptor queue scheduler
`timescale 1ns/100ps
module dqs_sched_chk (
   input wire logic CLK,
   input wire logic ARST_N,
   input wire logic [11:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [63:0] AVS_WRITEDATA,
   input wire logic AVS_WAITREQUEST,
   input wire logic ADDR64,
   input wire logic DISP_VALID,
   input wire logic DISP_READY,
   input wire dqs_pkg::dqs_disp_t DISP,
   input wire dqs_pkg::dqs_evt_t MOVER_EVT,
   input wire dqs_pkg::dqs_enq_t ENQ
);
   logic wait_ff;
   logic seen_ff;
   logic [15:0] sz_ff;
   wire done = MOVER_EVT.req_done || MOVER_EVT.desc_done || MOVER_EVT.chain_done;
   wire sz_wr = AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS[11:3] == 9'h022;
   // Error keeps the mover busy until a later done
   wire nxt_wait = (DISP_VALID && DISP_READY) || (wait_ff && !done);
   wire [15:0] exp_len = (sz_ff == 16'h0000) ? 16'hffff : sz_ff;
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         wait_ff <= 1'b0;
         seen_ff <= 1'b0;
         sz_ff <= 16'h0000;
      end else begin
         wait_ff <= nxt_wait;
         seen_ff <= seen_ff || sz_wr;
         sz_ff <= sz_wr ? AVS_WRITEDATA[15:0] : sz_ff;
      end
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (!ARST_N);
   wait_once_a: assert property (
      (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
      else $error("bus wait longer than one cycle");
   enq_count_a: assert property (ENQ.valid |-> $past(AVS_WRITE && !AVS_WAITREQUEST) &&
      ENQ.count == $past(AVS_WRITEDATA[5:0]) && ENQ.chain[5:0] == 6'h00)
      else $error("enqueue count not from write data");
   enq_upper_a: assert property (
      ENQ.valid && !ADDR64 |-> ENQ.chain[63:32] == 32'h0)
      else $error("upper address kept in narrow mode");
   word_four_a: assert property (DISP_VALID |-> DISP.word4_en == ADDR64)
      else $error("word four enable wrong");
   disp_hold_a: assert property (
      DISP_VALID && !DISP_READY |=> DISP_VALID && $stable(DISP))
      else $error("dispatch changed before taken");
   err_hold_a: assert property (
      wait_ff && MOVER_EVT.error |=> !DISP_VALID [*4])
      else $error("dispatch during halt");
   max_len_a: assert property (DISP_VALID && seen_ff |-> DISP.max_len == exp_len)
      else $error("request size wrong");
   queue_id_a: assert property (DISP_VALID |-> DISP.queue != 2'h3)
      else $error("no such queue");
   cover property (ENQ.valid);
   cover property (DISP_VALID && DISP_READY);
   cover property (wait_ff && MOVER_EVT.error);
endmodule // dqs_sched_chk
bind dqs_sched dqs_sched_chk dqs_sched_chk_inst (.CLK(CLK), .ARST_N(ARST_N),
   .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
   .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .ADDR64(ADDR64),
   .DISP_VALID(DISP_VALID), .DISP_READY(DISP_READY), .DISP(DISP), .MOVER_EVT(MOVER_EVT),
   .ENQ(ENQ));

/* File: dqs_mover_model.sv */
// Behavioural DMA mover answering dispatches
`timescale 1ns/100ps
module dqs_mover_model #(parameter int LAT = 6) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic valid,
   input wire logic [1:0] kind,
   output logic ready,
   output dqs_pkg::dqs_evt_t evt
);
   logic busy_ff;
   logic erred_ff;
   int cnt_ff;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ready <= 1'b0;
         busy_ff <= 1'b0;
         erred_ff <= 1'b0;
         cnt_ff <= 0;
         evt <= '0;
      end else begin
         evt <= '0;
         // Ready a cycle late, so the dispatch must wait
         ready <= valid && !busy_ff && !ready;
         if (valid && ready) begin
            busy_ff <= 1'b1;
            cnt_ff <= LAT;
         end else if (busy_ff && cnt_ff != 0) begin
            cnt_ff <= cnt_ff - 1;
         end else if (busy_ff) begin
            if (kind == 2'h3 && !erred_ff) begin
               evt.error <= 1'b1;
               erred_ff <= 1'b1;
               cnt_ff <= LAT;
            end else begin
               evt.req_done <= kind == 2'h0;
               evt.chain_done <= kind == 2'h1 || kind == 2'h3;
               evt.desc_done <= kind == 2'h2;
               erred_ff <= 1'b0;
               busy_ff <= 1'b0;
            end
         end
      end
   end
endmodule // dqs_mover_model

/* File: tb_top.sv */
// Self-checking bench of the descriptor queue scheduler
`timescale 1ns/100ps
module tb_top;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [11:0] adr = 12'h000;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [63:0] wd = 64'h0;
   logic [7:0] be = 8'hff;
   logic a64 = 1'b0;
   logic [1:0] kind = 2'h1;
   logic [63:0] rdat;
   logic wreq;
   logic dv;
   logic dr;
   logic [2:0] thr;
   dqs_pkg::dqs_disp_t disp;
   dqs_pkg::dqs_evt_t evt;
   dqs_pkg::dqs_enq_t enq_o;
   logic [63:0] rv;
   logic [63:0] last_slot;
   int err_count = 0;
   int n_compared = 0;
   logic [1:0] gq[$];
   always #25 clk = ~clk;
   always @(posedge clk) begin
      if (dv && dr) begin
         gq.push_back(disp.queue);
         last_slot = disp.slot;
      end
   end
   dqs_sched dqs_sched_inst (.CLK(clk), .ARST_N(arst_n), .AVS_ADDRESS(adr), .AVS_READ(rd),
      .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat),
      .AVS_WAITREQUEST(wreq), .ADDR64(a64), .DISP_VALID(dv), .DISP_READY(dr), .DISP(disp),
      .MOVER_EVT(evt), .ENQ(enq_o), .THRESH(thr));
   dqs_mover_model dqs_mover_model_inst (.clk(clk), .arst_n(arst_n), .valid(dv),
      .kind(kind), .ready(dr), .evt(evt));
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [11:0] a, input logic [63:0] d,
         input logic [7:0] b);
      @(posedge clk);
      adr <= a;
      wd <= d;
      be <= b;
      wr <= w;
      rd <= !w;
      // Held until waitrequest is sampled low; only the watchdog ends a hang
      do begin
         @(posedge clk);
      end while (wreq !== 1'b0);
      rv = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task automatic wr64(input logic [11:0] a, input logic [63:0] d);
      bus(1'b1, a, d, 8'hff);
   endtask
   task automatic rd64(input logic [11:0] a);
      bus(1'b0, a, 64'h0, 8'hff);
   endtask
   // bounds in diagnostic mode, diag cleared last
   task automatic setup();
      wr64(12'h100, 64'h01);
      for (int q = 0; q < 3; q++) begin
         wr64(12'(q * 64), 64'h10000 + 64'(q * 512));
         wr64(12'(q * 64 + 8), 64'h0);
         wr64(12'(q * 64 + 40), 64'h0);
      end
      // local range low bound set, request size cleared; chains stay above it
      wr64(12'h118, 64'h0004_0000);
      wr64(12'h110, 64'h0);
      wr64(12'h100, 64'h0);
   endtask
   // every queue fed by descriptor chains only
   task automatic enq(input int q, input logic [5:0] c);
      wr64(12'(q * 64 + 48), 64'h80000 + 64'(c));
      @(negedge clk);
      check(64'({enq_o.valid, enq_o.queue, enq_o.count}), 64'({1'b1, 2'(q), c}));
      check(enq_o.chain, 64'h80000);
   endtask
   task automatic go(input logic [7:0] c, input int k);
      gq.delete();
      wr64(12'h100, 64'(c));
      for (int n = 0; n < 400 && gq.size() < k; n++) @(posedge clk);
      check(64'(gq.size() >= k), 64'h1);
   endtask
   task automatic drain(input int q);
      int n;
      n = 0;
      do begin
         rd64(12'(q * 64 + 32));
         n++;
      end while (rv !== 64'h0 && n < 50);
      check(rv, 64'h0);
   endtask
   task automatic t_regs();
      rd64(12'h100);
      check(rv, 64'h01);
      wr64(12'h040, 64'hffff_ffff_ffff_ffff);
      rd64(12'h044);
      check(rv, 64'h0000_0000_ffff_fe00);
      rd64(12'h050);
      check(rv, 64'h0000_0000_ffff_fe00);
      rd64(12'h060);
      check(rv, 64'h0);
      a64 <= 1'b1;
      // split update, no other master active
      bus(1'b1, 12'h040, 64'h0000_0001_0000_0000, 8'hf0);
      bus(1'b1, 12'h044, 64'h0000_0000_0000_0600, 8'h0f);
      rd64(12'h040);
      check(rv, 64'h0000_0001_0000_0600);
      rd64(12'h1f8);
      check(rv, 64'h0);
      wr64(12'h048, 64'h3);
      wr64(12'h100, 64'h0);
      wr64(12'h048, 64'h5);
      rd64(12'h048);
      check(rv, 64'h3);
   endtask
   task automatic t_thresh();
      setup();
      wr64(12'h0a8, 64'h10);
      enq(2, 6'h01);
      check(64'(thr[2]), 64'h0);
      enq(2, 6'h02);
      check(64'(thr[2]), 64'h1);
      wr64(12'h0a8, 64'h0);
      @(negedge clk);
      check(64'(thr), 64'h0);
   endtask
   task automatic t_wrap();
      setup();
      kind <= 2'h1;
      go(8'h0a, 0);
      for (int i = 0; i < 65; i++) begin
         enq(1, 6'h3f);
         check(enq_o.slot, 64'h10200 + 64'((i * 8) % 512));
         drain(1);
         check(last_slot, 64'h10200 + 64'((i * 8) % 512));
      end
      rd64(12'h050);
      check(rv, 64'h10208);
   endtask
   task automatic t_arb();
      setup();
      a64 <= 1'b0;
      enq(2, 6'h01);
      enq(1, 6'h01);
      enq(0, 6'h01);
      enq(1, 6'h01);
      enq(2, 6'h01);
      go(8'h0a, 5);
      check(64'(gq[0]), 64'h0);
      check(64'(gq[1] != gq[2]), 64'h1);
      check(64'(gq[3]), 64'(gq[1]));
      check(64'(gq[4]), 64'(gq[2]));
      setup();
      a64 <= 1'b1;
      wr64(12'h110, 64'h200);
      for (int q = 0; q < 6; q++) enq(q / 2, 6'h01);
      go(8'h0e, 6);
      for (int i = 0; i < 3; i++) begin
         check(64'(gq[i] != gq[(i + 1) % 3]), 64'h1);
         check(64'(gq[i + 3]), 64'(gq[i]));
      end
   endtask
   task automatic t_rearb();
      for (int m = 0; m < 3; m++) begin
         setup();
         enq(1, 6'h01);
         enq(2, 6'h01);
         kind <= 2'(m);
         go(8'h02 | 8'(m << 3), 2);
         check(64'(gq[0] != gq[1]), 64'h1);
      end
   endtask
   task automatic t_err();
      int n;
      n = 0;
      setup();
      kind <= 2'h3;
      enq(0, 6'h01);
      enq(0, 6'h01);
      go(8'h0a, 1);
      do begin
         rd64(12'h108);
         n++;
      end while (rv[7] !== 1'b1 && n < 20);
      check(64'(rv[7]), 64'h1);
      drain(0);
      check(64'(gq.size()), 64'h2);
   endtask
   task automatic wrap_up();
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk);
      arst_n <= 1'b1;
      t_regs();
      t_thresh();
      t_wrap();
      t_arb();
      t_rearb();
      t_err();
      wrap_up();
   end
   initial begin
      #1000000;
      err_count++;
      wrap_up();
   end
endmodule // tb_top
